//--- shared/fault_qual_pkg.sv
package fault_qual_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ARM_DELAY_MS = 20_000;
  localparam int unsigned RIPPLE_DELAY_MS = 1_500;
  localparam int unsigned STRETCH_MS = 2_400;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned ARM_DELAY_CYC = ARM_DELAY_MS * CYC_PER_MS;
  localparam int unsigned RIPPLE_DELAY_CYC = RIPPLE_DELAY_MS * CYC_PER_MS;
  localparam int unsigned STRETCH_CYC = STRETCH_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 32;
  // Glitch filter length in cycles for the cable interlock input
  localparam int unsigned GLITCH_CYC = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  // ----------------------------------------------------------------
  // Arming sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ARM_OFF = 3'b001,
    ARM_WAIT = 3'b010,
    ARM_ON = 3'b100
  } arm_state_t;
endpackage : fault_qual_pkg

//--- shared/delay_if.sv
`timescale 1ns/10ps
// Carries one qualifying delay: a level in, a terminal count, a qualified level out
interface delay_if;
  logic level;
  logic [31:0] limit;
  logic qualified;
  modport owner (output level, output limit, input qualified);
  modport timer (input level, input limit, output qualified);
endinterface : delay_if

//--- rtl/hold_timer.sv
`timescale 1ns/10ps
// Output rises once the input has stayed high for limit cycles; any low resets at once
module hold_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Delay channel
  delay_if.timer dly
);
  import fault_qual_pkg::*;

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic done;

  assign done = (count_r >= dly.limit);
  assign count_nxt = !dly.level ? CNT_ZERO : (done ? count_r : count_r + CNT_ONE);
  assign dly.qualified = dly.level && done;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= CNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  drop_fast_a: assert property (@(posedge clock) disable iff (!rst_n)
    !dly.level |-> ##1 (count_r == CNT_ZERO))
    else $error("delay count not cleared on input low");
endmodule : hold_timer

//--- rtl/type1_fault_qualifier.sv
`timescale 1ns/10ps
module type1_fault_qualifier #(
  // Terminal counts; overridable so a bench can shorten the seconds-long delays
  parameter int unsigned ARM_CYC = fault_qual_pkg::ARM_DELAY_CYC,
  parameter int unsigned RIPPLE_CYC = fault_qual_pkg::RIPPLE_DELAY_CYC,
  parameter int unsigned STRETCH_LEN = fault_qual_pkg::STRETCH_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Controller sequencing
  input wire logic release_n,
  input wire logic latch_reset_n,
  // Fault sources
  input wire logic air_fault,
  input wire logic ripple_detect,
  input wire logic overvolt_cmp,
  input wire logic module_missing,
  input wire logic cable_loose,
  input wire logic repeat_fault,
  // Qualified outputs
  output logic sense_block_n,
  output logic indicate_blank_n,
  output logic air_ind_green,
  output logic air_ind_red,
  output logic overvolt,
  output logic overvolt_red,
  output logic cable_red,
  output logic imbalance_fault,
  output logic cable_fault,
  output logic turn_off,
  output logic [2:0] arm_state
);
  import fault_qual_pkg::*;

  // ----------------------------------------------------------------
  // Turn-on inhibit
  // ----------------------------------------------------------------
  delay_if arm_ch ();
  delay_if rip_ch ();
  arm_state_t state_r;
  arm_state_t state_nxt;
  logic armed;
  logic indicate_en;

  assign arm_ch.level = release_n;
  assign arm_ch.limit = ARM_CYC;
  hold_timer arm_timer (.clock(clock), .rst_n(rst_n), .dly(arm_ch));

  // Release is held low by the controller while off, so the delay sees it directly
  assign armed = release_n && arm_ch.qualified;
  assign indicate_en = release_n && arm_ch.qualified;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ARM_OFF: if (release_n) state_nxt = ARM_WAIT;
      ARM_WAIT: if (!release_n) state_nxt = ARM_OFF; else if (arm_ch.qualified) state_nxt = ARM_ON;
      ARM_ON: if (!release_n) state_nxt = ARM_OFF;
      default: state_nxt = ARM_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // Supply faults
  // ----------------------------------------------------------------
  // Ripple detect already comes from the 2x line band-pass comparator
  assign rip_ch.level = ripple_detect;
  assign rip_ch.limit = RIPPLE_CYC;
  hold_timer rip_timer (.clock(clock), .rst_n(rst_n), .dly(rip_ch));

  logic [4:0] glitch_r;
  logic cable_raw;
  logic cable_filt_r;
  logic air_gated;
  logic air_lat_r;
  logic ov_lat_r;
  logic cable_lat_r;
  logic any_fault;
  logic fault_d_r;
  logic [CNT_W-1:0] stretch_r;
  logic stretching;

  assign cable_raw = module_missing || cable_loose;
  assign air_gated = air_fault && armed;
  assign any_fault = air_gated || imbalance_fault || overvolt || cable_filt_r || repeat_fault;
  assign stretching = (stretch_r != CNT_ZERO);

  // Filter: output follows input only after the input differs from it for GLITCH_CYC cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      glitch_r <= 5'h00;
      cable_filt_r <= 1'b0;
    end else if (cable_raw == cable_filt_r) begin
      glitch_r <= 5'h00;
    end else if (glitch_r == 5'(GLITCH_CYC - 1)) begin
      glitch_r <= 5'h00;
      cable_filt_r <= cable_raw;
    end else begin
      glitch_r <= glitch_r + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Latches, stretcher and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ARM_OFF;
      air_lat_r <= 1'b0;
      ov_lat_r <= 1'b0;
      cable_lat_r <= 1'b0;
      fault_d_r <= 1'b0;
      stretch_r <= CNT_ZERO;
      sense_block_n <= 1'b0;
      indicate_blank_n <= 1'b0;
      air_ind_green <= 1'b0;
      air_ind_red <= 1'b0;
      overvolt <= 1'b0;
      overvolt_red <= 1'b0;
      cable_red <= 1'b0;
      imbalance_fault <= 1'b0;
      cable_fault <= 1'b0;
      turn_off <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // A fault still present wins over the reset so it retriggers at once
      air_lat_r <= air_gated || (air_lat_r && latch_reset_n);
      ov_lat_r <= overvolt || (ov_lat_r && latch_reset_n);
      cable_lat_r <= cable_filt_r || (cable_lat_r && latch_reset_n);
      fault_d_r <= any_fault;
      if (any_fault && !fault_d_r) begin
        stretch_r <= STRETCH_LEN;
      end else if (stretching) begin
        stretch_r <= stretch_r - CNT_ONE;
      end
      sense_block_n <= armed;
      indicate_blank_n <= indicate_en;
      air_ind_green <= indicate_en && !air_lat_r;
      air_ind_red <= indicate_en && air_lat_r;
      overvolt <= overvolt_cmp;
      overvolt_red <= ov_lat_r;
      cable_red <= cable_lat_r;
      imbalance_fault <= rip_ch.qualified;
      cable_fault <= cable_filt_r;
      turn_off <= any_fault || stretching;
    end
  end

  assign arm_state = state_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  blank_dark_a: assert property (@(posedge clock) disable iff (!rst_n)
    !indicate_blank_n |-> !air_ind_green && !air_ind_red)
    else $error("air indicator lit while blanked");
  sense_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !release_n |=> !sense_block_n)
    else $error("sensing armed while released low");
  air_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    !sense_block_n && $past(!sense_block_n) |-> !air_lat_r || $past(air_lat_r))
    else $error("air fault latched while blocked");
  ov_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    overvolt_cmp |=> overvolt ##2 overvolt_red)
    else $error("overvoltage not latched");
  stretch_min_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(any_fault) |=> turn_off [*8])
    else $error("turn-off pulse too short");
  arm_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ARM_ON && release_n |=> state_r == ARM_ON)
    else $error("arm state dropped while on");
  rip_short_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ripple_detect |-> ##2 !imbalance_fault)
    else $error("imbalance fault without ripple");
  cable_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    cable_filt_r |=> cable_fault && turn_off ##1 cable_red)
    else $error("cable fault not routed");
endmodule : type1_fault_qualifier

//--- verif/release_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Controller turn-on release, ON_DELAY stands in for the step-start lag
// ----------------------------------------------------------------
module release_ctrl_model #(
  parameter int ON_DELAY = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Sequencing
  input wire logic turn_on,
  input wire logic shutdown,
  output logic release_n
);
  int cnt;

  // Sampled on the rising edge like the controller's own flops, so a turn_on set by the bench never races it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      release_n <= 1'b0;
    end else if (!turn_on || shutdown) begin
      cnt <= 0;
      release_n <= 1'b0;
    end else if (cnt == ON_DELAY) begin
      release_n <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : release_ctrl_model

//--- verif/type1_fault_qualifier_tb.sv
`timescale 1ns/10ps
module type1_fault_qualifier_tb;
  import fault_qual_pkg::*;
  logic clock, rst_n, turn_on, release_n, latch_reset_n, air_fault, ripple_detect;
  logic overvolt_cmp, module_missing, cable_loose, repeat_fault;
  logic sense_block_n, indicate_blank_n, air_ind_green, air_ind_red, overvolt, overvolt_red;
  logic cable_red, imbalance_fault, cable_fault, turn_off;
  logic [2:0] arm_state;
  int n_fail = 0;
  int checks = 0;
  // Row: inputs {turn_on, repeat, ripple, air, loose, missing, ov_cmp}, outputs {sense, imb, off, cable, ov}
  localparam logic [11:0] ROWS [7] = '{12'h000, 12'h025, 12'h046, 12'h086, 12'h900, 12'h200, 12'h404};
  // Shortened terminal counts so the second-long delays fit the run; rows rely on 30 cycles < ARM_T and RIP_T
  localparam int ARM_T = 40;
  localparam int RIP_T = 50;
  localparam int STRETCH_T = 200;

  release_ctrl_model #(.ON_DELAY(4)) ctrl (.clock(clock), .rst_n(rst_n), .turn_on(turn_on),
    .shutdown(turn_off), .release_n(release_n));
  type1_fault_qualifier #(.ARM_CYC(ARM_T), .RIPPLE_CYC(RIP_T), .STRETCH_LEN(STRETCH_T))
    uut (.clock(clock), .rst_n(rst_n), .release_n(release_n),
    .latch_reset_n(latch_reset_n), .air_fault(air_fault), .ripple_detect(ripple_detect),
    .overvolt_cmp(overvolt_cmp), .module_missing(module_missing), .cable_loose(cable_loose),
    .repeat_fault(repeat_fault), .sense_block_n(sense_block_n), .indicate_blank_n(indicate_blank_n),
    .air_ind_green(air_ind_green), .air_ind_red(air_ind_red), .overvolt(overvolt),
    .overvolt_red(overvolt_red), .cable_red(cable_red), .imbalance_fault(imbalance_fault),
    .cable_fault(cable_fault), .turn_off(turn_off), .arm_state(arm_state));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cyc

  task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Full reset between cases, since the 200-cycle turn-off stretch outlives a 30-cycle table case
  task automatic do_reset();
    {turn_on, repeat_fault, ripple_detect, air_fault, cable_loose, module_missing, overvolt_cmp} = 7'h00;
    latch_reset_n = 1'b1;
    rst_n = 1'b0;
    wait_cyc(16);
    rst_n = 1'b1;
    wait_cyc(1);
  endtask : do_reset

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    #100_000;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Table cases, then hand-written ones
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      do_reset();
      {turn_on, repeat_fault, ripple_detect, air_fault, cable_loose, module_missing, overvolt_cmp} = ROWS[i][11:5];
      wait_cyc(30);
      chk("row_outputs", {1'b0, ROWS[i][4:0]}, {1'b0, sense_block_n, imbalance_fault, turn_off, cable_fault, overvolt});
    end
    do_reset();
    chk("reset_state", 6'h01, {overvolt_red, cable_red, turn_off, arm_state});
    overvolt_cmp = 1'b1;
    wait_cyc(1);
    chk("overvolt", 6'h01, {5'h00, overvolt});
    overvolt_cmp = 1'b0;
    wait_cyc(100);
    chk("ov_latch", 6'h03, {3'h0, overvolt, overvolt_red, turn_off});
    latch_reset_n = 1'b0;
    wait_cyc(2);
    latch_reset_n = 1'b1;
    chk("ov_cleared", 6'h00, {5'h00, overvolt_red});
    do_reset();
    cable_loose = 1'b1;
    wait_cyc(8);
    cable_loose = 1'b0;
    wait_cyc(20);
    chk("cable_glitch", 6'h00, {3'h0, cable_fault, cable_red, turn_off});
    cable_loose = 1'b1;
    wait_cyc(20);
    cable_loose = 1'b0;
    wait_cyc(20);
    chk("cable_latch", 6'h01, {5'h00, cable_red});
    do_reset();
    turn_on = 1'b1;
    air_fault = 1'b1;
    wait_cyc(12);
    chk("arm_wait", 6'h10, {arm_state, indicate_blank_n, air_ind_green, air_ind_red});
    chk("air_ignored", 6'h00, {4'h0, sense_block_n, turn_off});
    turn_on = 1'b0;
    wait_cyc(3);
    chk("arm_cleared", 6'h01, {3'h0, arm_state});
    // Full arming, an air trip, the turn-off stretch and a fresh delay on the next turn-on
    do_reset();
    turn_on = 1'b1;
    wait_cyc(ARM_T + 5);
    chk("arm_early", 6'h00, {4'h0, sense_block_n, indicate_blank_n});
    wait_cyc(1);
    chk("arm_done", 6'h3a, {sense_block_n, indicate_blank_n, air_ind_green, air_ind_red, arm_state[2], turn_off});
    air_fault = 1'b1;
    wait_cyc(2);
    chk("air_trip", 6'h03, {3'h0, air_ind_green, air_ind_red, turn_off});
    wait_cyc(1);
    chk("air_off", 6'h01, {sense_block_n, indicate_blank_n, air_ind_red, arm_state});
    wait_cyc(STRETCH_T - 2);
    chk("stretch_end", 6'h01, {5'h00, turn_off});
    air_fault = 1'b0;
    wait_cyc(1);
    chk("stretch_drop", 6'h00, {5'h00, turn_off});
    wait_cyc(ARM_T + 5);
    chk("rearm_early", 6'h00, {4'h0, sense_block_n, air_ind_red});
    wait_cyc(1);
    chk("rearm_red", 6'h05, {3'h0, sense_block_n, air_ind_green, air_ind_red});
    latch_reset_n = 1'b0;
    wait_cyc(2);
    latch_reset_n = 1'b1;
    chk("air_cleared", 6'h02, {4'h0, air_ind_green, air_ind_red});
    // Ripple just one cycle short of the qualifying time must not trip
    do_reset();
    ripple_detect = 1'b1;
    wait_cyc(RIP_T);
    ripple_detect = 1'b0;
    wait_cyc(5);
    chk("ripple_short", 6'h00, {4'h0, imbalance_fault, turn_off});
    ripple_detect = 1'b1;
    wait_cyc(RIP_T);
    chk("ripple_early", 6'h00, {4'h0, imbalance_fault, turn_off});
    wait_cyc(1);
    chk("ripple_trip", 6'h02, {4'h0, imbalance_fault, turn_off});
    wait_cyc(1);
    chk("ripple_off", 6'h03, {4'h0, imbalance_fault, turn_off});
    complete_run();
  end
endmodule : type1_fault_qualifier_tb
